// ---- logic/sbad_addr_decoder.sv ----
/*
 * Private address decoder of one bus master: maps an address onto a
 * slave number, external chip select and peripheral bus A slot.
 * Assumes the address is stable while the master requests.
 */
`timescale 1ns/1ps
`default_nettype none

module sbad_addr_decoder
    import sbad_pkg::*;
(
    input wire logic [31:0] addr_in,
    output logic hit_out,
    output logic [2:0] slave_out,
    output logic [2:0] cs_out,
    output logic [3:0] pba_idx_out,
    output logic pba_valid_out
);

    function automatic logic sbad_in_win(input logic [31:0] a,
                                         input logic [31:0] base,
                                         input logic [31:0] mask);
        return (a & ~mask) == base;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Fixed map, no remap input exists at all (see RL1)
    always_comb begin
        hit_out = 1'b1;
        slave_out = SBAD_SLV_EXT;
        cs_out = SBAD_CS_0;
        pba_idx_out = 4'h0;
        pba_valid_out = 1'b0;
        if (sbad_in_win(addr_in, SBAD_BASE_CS0, SBAD_MASK_64M)) begin
            cs_out = SBAD_CS_0; // see RL2
        end else if (sbad_in_win(addr_in, SBAD_BASE_CS4, SBAD_MASK_64M)) begin
            cs_out = SBAD_CS_4; // see RL2
        end else if (sbad_in_win(addr_in, SBAD_BASE_CS2, SBAD_MASK_64M)) begin
            cs_out = SBAD_CS_2; // see RL2
        end else if (sbad_in_win(addr_in, SBAD_BASE_CS3, SBAD_MASK_64M)) begin
            cs_out = SBAD_CS_3; // see RL2
        end else if (sbad_in_win(addr_in, SBAD_BASE_CS1, SBAD_MASK_256M)) begin
            cs_out = SBAD_CS_1; // see RL3
        end else if (sbad_in_win(addr_in, SBAD_BASE_CS5, SBAD_MASK_64M)) begin
            cs_out = SBAD_CS_5; // see RL4
        end else if (sbad_in_win(addr_in, SBAD_BASE_BANK0,
                                 SBAD_MASK_16K)) begin
            slave_out = SBAD_SLV_BANK0; // see RL5
        end else if (sbad_in_win(addr_in, SBAD_BASE_BANK1,
                                 SBAD_MASK_16K)) begin
            slave_out = SBAD_SLV_BANK1; // see RL5
        end else if (sbad_in_win(addr_in, SBAD_BASE_DISP, SBAD_MASK_4K)) begin
            slave_out = SBAD_SLV_DISP; // see RL6, see RL17
        end else if (sbad_in_win(addr_in, SBAD_BASE_DMA, SBAD_MASK_1K)) begin
            slave_out = SBAD_SLV_DMA; // see RL6, see RL17
        end else if (sbad_in_win(addr_in, SBAD_BASE_USB, SBAD_MASK_1M)) begin
            slave_out = SBAD_SLV_USB; // see RL7, see RL17
        end else if (sbad_in_win(addr_in, SBAD_BASE_PBA, SBAD_MASK_1M)) begin
            slave_out = SBAD_SLV_PBA; // see RL7
            // Slots 0..13: serial, two-wire, sync serial, parallel I/O
            if (((addr_in & SBAD_PBA_UPPER_MASK) == 32'h0000_0000) &&
                (addr_in[SBAD_PBA_SLOT_LSB +: 4] <= SBAD_PBA_LAST_SLOT)) begin
                pba_idx_out = addr_in[SBAD_PBA_SLOT_LSB +: 4]; // see RL13
                pba_valid_out = 1'b1; // see RL14, see RL15
            end
        end else if (sbad_in_win(addr_in, SBAD_BASE_PBB, SBAD_MASK_1M)) begin
            slave_out = SBAD_SLV_PBB; // see RL7
        end else begin
            hit_out = 1'b0; // see RL8
        end
    end

endmodule // sbad_addr_decoder

`default_nettype wire

// ---- logic/sbad_matrix.sv ----
/*
 * Bus matrix core: one private decoder per master, one arbiter per
 * slave, error completion of unmapped accesses.
 * Assumes masters hold request and address until done or error, and
 * slaves other than the memory banks pulse done when a transfer ends.
 */
// Summary of operation
// (RL1) One fixed map, never remapped, even boot
// (RL2) Four 64M windows to chip selects 0,4,2,3
// (RL3) 256M at 0x1000_0000 selects chip select 1
// (RL4) 64M at 0x2000_0000 selects chip select 5
// (RL5) Two 16K memory banks at 0x2400_0000/4000
// (RL6) Display 4K and DMA 1K config windows
// (RL7) USB, bus A, bus B 1M windows
// (RL8) Unmapped access returns error to its master
// (RL9) Every master has its own decoder
// (RL10) Master numbers 0-5, 8, 9 by port
// (RL11) Every slave has its own arbiter
// (RL12) Slave numbers 0-7 as listed
// (RL13) Bus A: serial, serial, two-wire at 0x800
// (RL14) Bus A: four serial ports from 0xFFE00C00
// (RL15) Bus A: sync serial then parallel I/O slots
// (RL16) Memory banks complete in one cycle
// (RL17) Config and USB windows are matrix slaves
// (RL18) One grant per slave, held until done
`timescale 1ns/1ps
`default_nettype none

module sbad_matrix
    import sbad_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] mst_req_in,
    input wire logic [7:0][31:0] mst_addr_in,
    output logic [7:0] mst_gnt_out,
    output logic [7:0] mst_done_out,
    output logic [7:0] mst_err_out,
    input wire logic [7:0] slv_done_in,
    output logic [7:0] slv_gnt_out,
    output logic [7:0][3:0] slv_mst_out,
    output logic [7:0][31:0] slv_addr_out,
    output logic [2:0] ext_cs_out,
    output logic [3:0] pba_slot_out,
    output logic pba_slot_valid_out
);

    sbad_state_t state_reg;
    sbad_state_t state_next;

    logic [7:0] dec_hit;
    logic [7:0][2:0] dec_slave;
    logic [7:0][2:0] dec_cs;
    logic [7:0][3:0] dec_pba_idx;
    logic [7:0] dec_pba_valid;
    logic [7:0] slv_fin;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] sbad_mst_num(input logic [2:0] idx);
        return SBAD_MST_NUM[idx]; // see RL10
    endfunction

    function automatic logic sbad_is_bank(input logic [2:0] s);
        return (s == SBAD_SLV_BANK0) || (s == SBAD_SLV_BANK1);
    endfunction

    // Fixed priority: lowest port index wins; fairness left to masters
    function automatic logic [3:0] sbad_pick(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Private decoders

    for (genvar g = 0; g < SBAD_NUM_MST; g++) begin : g_dec
        sbad_addr_decoder u_dec ( // see RL9
            .addr_in(mst_addr_in[g]),
            .hit_out(dec_hit[g]),
            .slave_out(dec_slave[g]),
            .cs_out(dec_cs[g]),
            .pba_idx_out(dec_pba_idx[g]),
            .pba_valid_out(dec_pba_valid[g])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // Transfer completion per slave

    always_comb begin
        for (int s = 0; s < SBAD_NUM_SLV; s++) begin
            // Banks have no wait states, so one granted cycle is all
            slv_fin[s] = state_reg.busy[s] &
                (sbad_is_bank(3'(s)) | slv_done_in[s]); // see RL16
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Arbiters and next state

    always_comb begin
        logic [7:0] want;
        logic [3:0] win;
        want = 8'h00;
        win = 4'h0;
        state_next = state_reg;
        for (int s = 0; s < SBAD_NUM_SLV; s++) begin // see RL11
            for (int m = 0; m < SBAD_NUM_MST; m++) begin
                want[m] = mst_req_in[m] & dec_hit[m] &
                    (dec_slave[m] == 3'(s)); // see RL12
            end
            win = sbad_pick(want);
            if (state_reg.busy[s]) begin
                // Grant stands until the transfer ends
                if (slv_fin[s]) begin
                    state_next.busy[s] = 1'b0; // see RL18
                end
            end else if (win[3]) begin
                state_next.busy[s] = 1'b1; // see RL18
                state_next.owner[s] = win[2:0];
                state_next.mnum[s] = sbad_mst_num(win[2:0]);
                state_next.addr[s] = mst_addr_in[win[2:0]];
                if (3'(s) == SBAD_SLV_EXT) begin
                    state_next.cs = dec_cs[win[2:0]]; // see RL2
                end
                if (3'(s) == SBAD_SLV_PBA) begin
                    state_next.pba_idx = dec_pba_idx[win[2:0]];
                    state_next.pba_valid = dec_pba_valid[win[2:0]];
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg.busy <= 8'h00;
            state_reg.owner <= {SBAD_NUM_SLV{SBAD_RST_IDX}};
            state_reg.mnum <= {SBAD_NUM_SLV{SBAD_RST_NUM}};
            state_reg.addr <= {SBAD_NUM_SLV{SBAD_RST_ADDR}};
            state_reg.cs <= SBAD_CS_0;
            state_reg.pba_idx <= 4'h0;
            state_reg.pba_valid <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Master side handshake

    always_comb begin
        mst_gnt_out = 8'h00;
        mst_done_out = 8'h00;
        for (int m = 0; m < SBAD_NUM_MST; m++) begin
            for (int s = 0; s < SBAD_NUM_SLV; s++) begin
                if (state_reg.busy[s] && (state_reg.owner[s] == 3'(m))) begin
                    mst_gnt_out[m] = 1'b1;
                    mst_done_out[m] = slv_fin[s];
                end
            end
        end
    end

    // Unmapped access ends at once with an error
    assign mst_err_out = mst_req_in & ~dec_hit; // see RL8

    assign slv_gnt_out = state_reg.busy;
    assign slv_mst_out = state_reg.mnum;
    assign slv_addr_out = state_reg.addr;
    assign ext_cs_out = state_reg.cs;
    assign pba_slot_out = state_reg.pba_idx;
    assign pba_slot_valid_out = state_reg.pba_valid;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    map_fixed_a: assert property ( // see RL1
        $stable(mst_addr_in[0]) |-> $stable(dec_slave[0]) &&
            $stable(dec_hit[0]) && $stable(dec_cs[0]))
        else $error("decode changed for a steady address");

    cs_four_a: assert property ( // see RL2
        (mst_addr_in[2][31:26] == 6'h01) |->
            dec_hit[2] && dec_slave[2] == SBAD_SLV_EXT &&
            dec_cs[2] == SBAD_CS_4)
        else $error("second 64M window not chip select 4");

    cs_one_a: assert property ( // see RL3
        (mst_addr_in[6][31:28] == 4'h1) |->
            dec_slave[6] == SBAD_SLV_EXT && dec_cs[6] == SBAD_CS_1)
        else $error("256M window not chip select 1");

    cs_five_a: assert property ( // see RL4
        (mst_addr_in[0][31:26] == 6'h08) |-> dec_cs[0] == SBAD_CS_5)
        else $error("window at 0x2000_0000 not chip select 5");

    bank_map_a: assert property ( // see RL5
        (mst_addr_in[4][31:14] == 18'h0_9001) |->
            dec_hit[4] && dec_slave[4] == SBAD_SLV_BANK1)
        else $error("bank 1 window misdecoded");

    dma_edge_a: assert property ( // see RL6
        (mst_addr_in[3][31:10] == 22'h3F_C801) |-> !dec_hit[3])
        else $error("address past DMA window decoded");

    bus_b_a: assert property ( // see RL7
        (mst_addr_in[3][31:20] == 12'hFFF) |-> dec_slave[3] == SBAD_SLV_PBB)
        else $error("bus B window misdecoded");

    err_resp_a: assert property ( // see RL8
        (mst_req_in[0] && !dec_hit[0]) |->
            mst_err_out[0] && !mst_gnt_out[0] ##1 !slv_gnt_out[0] ||
            state_reg.owner[0] != 3'h0 || !mst_req_in[0] || dec_hit[0])
        else $error("unmapped access without error");

    mst_num_a: assert property ( // see RL10
        slv_gnt_out[4] |-> slv_mst_out[4] == sbad_mst_num(state_reg.owner[4]))
        else $error("slave shows wrong master number");

    pba_slot_a: assert property ( // see RL14
        (mst_req_in[6] && mst_addr_in[6] == 32'hFFE0_1800) |->
            dec_pba_valid[6] && dec_pba_idx[6] == 4'h6)
        else $error("last serial port slot wrong");

    bank_one_a: assert property ( // see RL16
        $rose(slv_gnt_out[0]) |-> mst_done_out[state_reg.owner[0]] ##1
            !slv_gnt_out[0])
        else $error("bank grant longer than one cycle");

    grant_hold_a: assert property ( // see RL18
        (slv_gnt_out[4] && !slv_done_in[4]) |=>
            slv_gnt_out[4] && $stable(slv_mst_out[4]) &&
            $stable(slv_addr_out[4]))
        else $error("external grant dropped or moved early");

    cs_zero_a: assert property ( // see RL2
        (mst_addr_in[0][31:26] == 6'h00) |->
            dec_hit[0] && dec_cs[0] == SBAD_CS_0)
        else $error("first 64M window not chip select 0");

    cs_two_a: assert property ( // see RL2
        (mst_addr_in[3][31:26] == 6'h02) |->
            dec_hit[3] && dec_cs[3] == SBAD_CS_2)
        else $error("third 64M window not chip select 2");

    cs_three_a: assert property ( // see RL2
        (mst_addr_in[4][31:26] == 6'h03) |->
            dec_hit[4] && dec_cs[4] == SBAD_CS_3)
        else $error("fourth 64M window not chip select 3");

    ext_cs_a: assert property ( // see RL3
        (slv_gnt_out[4] && slv_addr_out[4][31:28] == 4'h1) |->
            ext_cs_out == SBAD_CS_1)
        else $error("chip select 1 not driven out");

    bank_zero_a: assert property ( // see RL5
        (mst_addr_in[2][31:14] == 18'h0_9000) |->
            dec_hit[2] && dec_slave[2] == SBAD_SLV_BANK0)
        else $error("bank 0 window misdecoded");

    disp_win_a: assert property ( // see RL6
        (mst_addr_in[6][31:12] == 20'hF_F000) |->
            dec_hit[6] && dec_slave[6] == SBAD_SLV_DISP)
        else $error("display config window misdecoded");

    dma_win_a: assert property ( // see RL6
        (mst_addr_in[0][31:10] == 22'h3F_C800) |->
            dec_hit[0] && dec_slave[0] == SBAD_SLV_DMA)
        else $error("DMA config window misdecoded");

    bus_a_win_a: assert property ( // see RL7
        (mst_addr_in[0][31:20] == 12'hFFE) |->
            dec_hit[0] && dec_slave[0] == SBAD_SLV_PBA)
        else $error("bus A window misdecoded");

    unmapped_a: assert property ( // see RL8
        (mst_addr_in[7][31:20] == 12'hFF1) |-> !dec_hit[7])
        else $error("hole between config windows decoded");

    own_dec_a: assert property ( // see RL9
        mst_req_in[7] |-> mst_err_out[7] == !dec_hit[7])
        else $error("master 7 error not from its own decoder");

    bus_a_slave_a: assert property ( // see RL12
        slv_gnt_out[2] |-> slv_addr_out[2][31:20] == 12'hFFE)
        else $error("slave 2 granted outside bus A");

    two_wire_slot_a: assert property ( // see RL13
        (mst_addr_in[2] == 32'hFFE0_0800) |->
            dec_pba_valid[2] && dec_pba_idx[2] == 4'h2)
        else $error("two-wire slot wrong");

    slot_end_a: assert property ( // see RL15
        (mst_addr_in[5] == 32'hFFE0_3400) |->
            dec_pba_valid[5] && dec_pba_idx[5] == 4'hD)
        else $error("last parallel I/O slot wrong");

    slot_past_a: assert property ( // see RL15
        (mst_addr_in[6][31:10] == 22'h3F_F80E) |->
            dec_slave[6] == SBAD_SLV_PBA && !dec_pba_valid[6])
        else $error("slot past parallel I/O marked valid");

    sync_slot_a: assert property ( // see RL15
        (slv_addr_out[2] == 32'hFFE0_2400) |->
            pba_slot_valid_out && pba_slot_out == 4'h9)
        else $error("third sync serial slot wrong");

    bank_short_a: assert property ( // see RL16
        slv_gnt_out[1] |=> !slv_gnt_out[1])
        else $error("bank 1 grant longer than one cycle");

    usb_win_a: assert property ( // see RL17
        (mst_addr_in[2][31:20] == 12'hFF3) |->
            dec_hit[2] && dec_slave[2] == SBAD_SLV_USB)
        else $error("USB window not a matrix slave");

    owner_gnt_a: assert property ( // see RL18
        slv_gnt_out[4] |-> mst_gnt_out[state_reg.owner[4]])
        else $error("external owner not shown granted");

    err_seen_c: cover property (mst_err_out[0]);
    bank_xfer_c: cover property ($rose(slv_gnt_out[1]));
    ext_xfer_c: cover property (slv_gnt_out[4] ##[1:20] slv_done_in[4]);
    two_req_c: cover property (mst_req_in[0] && mst_req_in[1] &&
        dec_slave[0] == dec_slave[1] && dec_hit[0] && dec_hit[1]);

endmodule // sbad_matrix

`default_nettype wire

// ---- logic/sbad_pkg.sv ----
/*
 * Constants and types shared by the system bus address decoder.
 * Assumes a single 20 MHz bus clock and a 32-bit physical address space.
 */
`default_nettype none

package sbad_pkg;

    localparam int SBAD_NUM_MST = 8;
    localparam int SBAD_NUM_SLV = 8;

    // Master numbers by port index 0..7
    localparam logic [7:0][3:0] SBAD_MST_NUM = {
        4'h9, 4'h8, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0
    };

    // Slave numbers
    localparam logic [2:0] SBAD_SLV_BANK0 = 3'h0;
    localparam logic [2:0] SBAD_SLV_BANK1 = 3'h1;
    localparam logic [2:0] SBAD_SLV_PBA = 3'h2;
    localparam logic [2:0] SBAD_SLV_PBB = 3'h3;
    localparam logic [2:0] SBAD_SLV_EXT = 3'h4;
    localparam logic [2:0] SBAD_SLV_USB = 3'h5;
    localparam logic [2:0] SBAD_SLV_DISP = 3'h6;
    localparam logic [2:0] SBAD_SLV_DMA = 3'h7;

    // Window sizes as address masks
    localparam logic [31:0] SBAD_MASK_256M = 32'h0FFF_FFFF;
    localparam logic [31:0] SBAD_MASK_64M = 32'h03FF_FFFF;
    localparam logic [31:0] SBAD_MASK_1M = 32'h000F_FFFF;
    localparam logic [31:0] SBAD_MASK_16K = 32'h0000_3FFF;
    localparam logic [31:0] SBAD_MASK_4K = 32'h0000_0FFF;
    localparam logic [31:0] SBAD_MASK_1K = 32'h0000_03FF;

    // Window base addresses
    localparam logic [31:0] SBAD_BASE_CS0 = 32'h0000_0000;
    localparam logic [31:0] SBAD_BASE_CS4 = 32'h0400_0000;
    localparam logic [31:0] SBAD_BASE_CS2 = 32'h0800_0000;
    localparam logic [31:0] SBAD_BASE_CS3 = 32'h0C00_0000;
    localparam logic [31:0] SBAD_BASE_CS1 = 32'h1000_0000;
    localparam logic [31:0] SBAD_BASE_CS5 = 32'h2000_0000;
    localparam logic [31:0] SBAD_BASE_BANK0 = 32'h2400_0000;
    localparam logic [31:0] SBAD_BASE_BANK1 = 32'h2400_4000;
    localparam logic [31:0] SBAD_BASE_DISP = 32'hFF00_0000;
    localparam logic [31:0] SBAD_BASE_DMA = 32'hFF20_0000;
    localparam logic [31:0] SBAD_BASE_USB = 32'hFF30_0000;
    localparam logic [31:0] SBAD_BASE_PBA = 32'hFFE0_0000;
    localparam logic [31:0] SBAD_BASE_PBB = 32'hFFF0_0000;

    // External chip select codes
    localparam logic [2:0] SBAD_CS_0 = 3'h0;
    localparam logic [2:0] SBAD_CS_1 = 3'h1;
    localparam logic [2:0] SBAD_CS_2 = 3'h2;
    localparam logic [2:0] SBAD_CS_3 = 3'h3;
    localparam logic [2:0] SBAD_CS_4 = 3'h4;
    localparam logic [2:0] SBAD_CS_5 = 3'h5;

    // Peripheral bus A slots of 0x400 bytes
    localparam int SBAD_PBA_SLOT_LSB = 10;
    localparam logic [31:0] SBAD_PBA_UPPER_MASK = 32'h000F_C000;
    localparam logic [3:0] SBAD_PBA_LAST_SLOT = 4'hD;

    // Reset values
    localparam logic [2:0] SBAD_RST_IDX = 3'h0;
    localparam logic [3:0] SBAD_RST_NUM = 4'h0;
    localparam logic [31:0] SBAD_RST_ADDR = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] busy;
        logic [7:0][2:0] owner;
        logic [7:0][3:0] mnum;
        logic [7:0][31:0] addr;
        logic [2:0] cs;
        logic [3:0] pba_idx;
        logic pba_valid;
    } sbad_state_t;

endpackage

`default_nettype wire

// ---- verification/sbad_slave_model.sv ----
/*
 * Far side of the bus matrix: slaves that end each granted transfer
 * after a settable number of wait cycles.
 * Assumes grants stand until the done cycle and drop at the next edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sbad_slave_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [3:0] wait_in,
    input wire logic [7:0] slv_gnt_in,
    output logic [7:0] slv_done_out
);

    logic [7:0][3:0] cnt_reg;

    // Count restarts with every grant so a slow slave stalls each transfer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= '0;
        end else begin
            for (int s = 0; s < 8; s++) begin
                cnt_reg[s] <= slv_gnt_in[s] ? cnt_reg[s] + 4'h1 : 4'h0;
            end
        end
    end

    // One done pulse wait_in cycles into a grant; banks raise it only when wait_in is 0, and the matrix ignores it
    always_comb begin
        for (int s = 0; s < 8; s++) begin
            slv_done_out[s] = slv_gnt_in[s] &&
                (cnt_reg[s] == wait_in);
        end
    end

endmodule // sbad_slave_model

`default_nettype wire

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench of the bus matrix: map, errors, bus A slots,
 * arbitration and reset. Assumes sbad_slave_model answers the slaves.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    logic clk_in, rstn_in;
    logic [7:0] req, mst_gnt, mst_done, mst_err, slv_done, slv_gnt;
    logic [7:0][31:0] addr, slv_addr;
    logic [7:0][3:0] slv_mst;
    logic [2:0] ext_cs;
    logic [3:0] pba_slot, slv_wait;
    logic pba_valid;
    int fails, num_checks;

    localparam logic [7:0][3:0] mst_num_exp = {
        4'h9, 4'h8, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    localparam logic [31:0] map_a [20] = '{
        32'h0000_0000, 32'h03FF_FFFC, 32'h0400_0000, 32'h0800_0000,
        32'h0C00_0000, 32'h0FFF_FFFC, 32'h1000_0000, 32'h1FFF_FFFC,
        32'h2000_0000, 32'h23FF_FFFC, 32'h2400_0000, 32'h2400_3FFC,
        32'h2400_4000, 32'h2400_7FFC, 32'hFF00_0000, 32'hFF00_0FFC,
        32'hFF20_0000, 32'hFF20_03FC, 32'hFF30_0000, 32'hFFF0_0000};
    localparam logic [2:0] map_s [20] = '{
        3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4,
        3'h0, 3'h0, 3'h1, 3'h1, 3'h6, 3'h6, 3'h7, 3'h7, 3'h5, 3'h3};
    localparam logic [2:0] map_c [20] = '{
        3'h0, 3'h0, 3'h4, 3'h2, 3'h3, 3'h3, 3'h1, 3'h1, 3'h5, 3'h5,
        3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
    localparam logic [31:0] bad_a [8] = '{
        32'h2400_8000, 32'h2C00_0000, 32'hFF00_1000, 32'hFF20_0400,
        32'hFF40_0000, 32'hFFD0_0000, 32'h8000_0000, 32'hFF10_0000};

    sbad_matrix u_sbad_matrix (.clk_in(clk_in), .rstn_in(rstn_in),
        .mst_req_in(req), .mst_addr_in(addr), .mst_gnt_out(mst_gnt),
        .mst_done_out(mst_done), .mst_err_out(mst_err),
        .slv_done_in(slv_done), .slv_gnt_out(slv_gnt),
        .slv_mst_out(slv_mst), .slv_addr_out(slv_addr),
        .ext_cs_out(ext_cs), .pba_slot_out(pba_slot),
        .pba_slot_valid_out(pba_valid));

    sbad_slave_model u_sbad_slave_model (.clk_in(clk_in),
        .rstn_in(rstn_in), .wait_in(slv_wait), .slv_gnt_in(slv_gnt),
        .slv_done_out(slv_done));

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Bounded wait for the end of a transfer, then release the request
    task automatic wait_done(input int m);
        int n;
        n = 0;
        while (mst_done[m] !== 1'b1) begin
            if (n++ > 20) begin
                fails++;
                $display("BAD done expected 1 seen timeout");
                conclude();
            end
            @(negedge clk_in);
        end
        req[m] = 1'b0;
        @(negedge clk_in);
    endtask

    task automatic xfer(input int m, input logic [31:0] a,
                        input logic [2:0] s);
        @(negedge clk_in);
        req[m] = 1'b1;
        addr[m] = a;
        @(negedge clk_in);
        check("mst_gnt", 32'(mst_gnt[m]), 32'h1);
        check("slv_gnt", 32'(slv_gnt[s]), 32'h1);
        check("slv_mst", 32'(slv_mst[s]), 32'(mst_num_exp[m]));
        check("slv_addr", slv_addr[s], a);
        if (s < 3'h2) check("bank_done", 32'(mst_done[m]), 32'h1);
        wait_done(m);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_map();
        slv_wait = 4'h2;
        foreach (map_a[i]) begin
            xfer(i % 8, map_a[i], map_s[i]);
            if (map_s[i] == 3'h4) begin
                check("cs", 32'(ext_cs), 32'(map_c[i]));
            end
        end
        $display("test_map finished");
    endtask

    task automatic test_error();
        foreach (bad_a[i]) begin
            @(negedge clk_in);
            req[i] = 1'b1;
            addr[i] = bad_a[i];
            #1 check("err_now", 32'(mst_err[i]), 32'h1);
            repeat (3) @(negedge clk_in);
            check("err_gnt", 32'(slv_gnt), 32'h0);
            check("err_hold", 32'(mst_err[i]), 32'h1);
            req[i] = 1'b0;
            #1 check("err_drop", 32'(mst_err[i]), 32'h0);
        end
        $display("test_error finished");
    endtask

    // Slots 14 up lie past the last peripheral: still bus A, slot reads 0
    task automatic test_pba();
        logic [31:0] slot_exp;
        slv_wait = 4'h0;
        for (int k = 0; k < 17; k++) begin
            slot_exp = (k < 14) ? 32'(k) : 32'h0;
            xfer(k % 8, 32'hFFE0_0000 + 32'(k) * 32'h0000_0400, 3'h2);
            check("pba_slot", 32'(pba_slot), slot_exp);
            check("pba_valid", 32'(pba_valid), 32'(k < 14));
        end
        $display("test_pba finished");
    endtask

    task automatic test_arb();
        int n;
        slv_wait = 4'h3;
        @(negedge clk_in);
        req = 8'h2B;
        addr[0] = 32'h2400_0100;
        addr[1] = 32'h1000_0000;
        addr[3] = 32'h0800_0000;
        addr[5] = 32'hFFF0_0000;
        @(negedge clk_in);
        check("arb_gnt", 32'(mst_gnt), 32'h23);
        check("arb_mst", 32'(slv_mst[4]), 32'h1);
        check("arb_cs", 32'(ext_cs), 32'h1);
        req[0] = 1'b0;
        n = 0;
        while (mst_done[1] !== 1'b1 && n < 20) begin
            check("arb_hold", 32'(mst_gnt[3]), 32'h0);
            n++;
            @(negedge clk_in);
        end
        check("arb_wait", 32'(n < 20), 32'h1);
        check("arb_done5", 32'(mst_done[5]), 32'h1);
        req[5] = 1'b0;
        wait_done(1);
        check("arb_idle", 32'(slv_gnt[4]), 32'h0);
        @(negedge clk_in);
        check("arb_next", 32'(slv_mst[4]), 32'h3);
        check("arb_cs2", 32'(ext_cs), 32'h2);
        wait_done(3);
        $display("test_arb finished");
    endtask

    // Reset in mid-transfer must clear every grant at once
    task automatic test_reset();
        @(negedge clk_in);
        req[2] = 1'b1;
        addr[2] = 32'h0C00_0000;
        @(negedge clk_in);
        rstn_in = 1'b0;
        req[2] = 1'b0;
        #1 check("rst_gnt", 32'(slv_gnt), 32'h0);
        check("rst_mgnt", 32'(mst_gnt), 32'h0);
        @(negedge clk_in);
        rstn_in = 1'b1;
        xfer(2, 32'h2400_4000, 3'h1);
        $display("test_reset finished");
    endtask

    initial begin
        req = '0;
        addr = '0;
        rstn_in = 1'b0;
        slv_wait = 4'h2;
        fails = 0;
        num_checks = 0;
        repeat (10) @(negedge clk_in);
        check("rst_slv", 32'(slv_gnt), 32'h0);
        rstn_in = 1'b1;
        test_map();
        test_error();
        test_pba();
        test_arb();
        test_reset();
        conclude();
    end

endmodule // tb_top

`default_nettype wire
